//--- mac_model.sv
`timescale 1ns/1ps
module mac_model
	import mii_port_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_tx_clock,
	input wire mii_tx_t i_word,
	input wire logic i_mgmt_go,
	output mii_tx_t o_tx,
	output logic o_mdc,
	output logic o_mdio
);
	mii_tx_t tx_q = '0;
	logic clk_q = 1'b0;
	logic mdc_q = 1'b0;
	logic mdio_q = 1'b1;
	logic [3:0] cnt = 4'h0;
	assign o_tx = tx_q;
	assign o_mdc = mdc_q;
	assign o_mdio = mdio_q;
	// New nibble just after the device clock rises
	always @(posedge i_clk) begin
		clk_q <= i_tx_clock;
		if (i_tx_clock && !clk_q) begin
			tx_q <= i_word;
		end
	end
	// 160 ns management clock, still outside frames; data pulled up when idle
	always @(posedge i_clk) begin
		cnt <= cnt + 4'h1;
		mdc_q <= i_mgmt_go && (mdc_q ^ (cnt == 4'hf));
		mdio_q <= i_mgmt_go ? !mdio_q : 1'b1;
	end
endmodule

//--- mii_clk_div.sv
`timescale 1ns/1ps
`include "mii_port_params.svh"

module mii_clk_div (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_speed100,
	output logic o_mii_clk,
	output logic o_rise,
	output logic o_fall
);

	localparam logic [5:0] HALF_100 = 6'(`MII_HALF_100_CYCLES);
	localparam logic [5:0] HALF_10 = 6'(`MII_HALF_10_CYCLES);

	logic [5:0] count_reg;
	logic [5:0] half_limit;
	logic wrap;

	assign half_limit = i_speed100 ? HALF_100 : HALF_10;
	assign wrap = (count_reg >= half_limit - 6'h01);

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			count_reg <= 6'h00;
		end else if (wrap) begin
			count_reg <= 6'h00;
		end else begin
			count_reg <= count_reg + 6'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_mii_clk <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else begin
			o_rise <= wrap && !o_mii_clk;
			o_fall <= wrap && o_mii_clk;
			if (wrap) begin
				o_mii_clk <= !o_mii_clk;
			end
		end
	end

endmodule

//--- mii_port.sv
`timescale 1ns/1ps
`include "mii_port_params.svh"

// Summary of operation
// - Normal mode samples only the four transmit data bits.
// - Transmit error at 100 Mbps sends error symbols; ignored at 10 Mbps.
// - Symbol mode uses transmit error input as transmit bit 4.
// - Device sources transmit clock: 2.5 MHz at 10 Mbps, 25 MHz at 100.
// - Device sources receive clock: 2.5 MHz at 10 Mbps, 25 MHz at 100.
// - Received nibble is driven synchronous to the receive clock.
// - Receive valid marks exactly the cycles carrying valid received data.
// - Receive error flags invalid symbols, synchronous to the receive clock.
// - Symbol mode uses receive error output as receive bit 4.
// - Collision output high for the whole collision, not tied to MII clocks.
// - Collision output stays low in full duplex.
// - Half duplex: carrier sense when transmit or receive medium is busy.
// - Full duplex: carrier sense only while receive medium is busy.
// - Strap high disables management; pins set control bits at every reset.
// - Strap low: pins load defaults at reset, then management owns the bits; here the Avalon bus writes them, the management port cannot.
// - Management data line is shared; each side drives only its own part; here the device never drives it.

module mii_port
	import mii_port_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_resetn,
	// Avalon-MM slave
	input wire logic [2:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// MII toward the MAC
	input wire logic [3:0] i_tx_nibble_p0,
	input wire logic i_tx_enable_p0,
	input wire logic i_tx_error_p0,
	output logic o_tx_clock_p0,
	output logic [3:0] o_rx_nibble_p0,
	output logic o_rx_valid_p0,
	output logic o_rx_error_p0,
	output logic o_rx_clock_p0,
	output logic o_collision_p0,
	output logic o_carrier_sense_p0,
	// Management pins and straps
	input wire logic i_mgmt_disable_strap_p0,
	input wire logic i_mgmt_clock_p0,
	input wire logic i_mgmt_data_p0,
	output logic o_mgmt_data_p0,
	output logic o_mgmt_data_oe_p0,
	input wire logic i_hw_speed100,
	input wire logic i_hw_full_duplex,
	input wire logic i_hw_symbol_mode,
	// Line side coding logic
	input wire logic [4:0] i_line_rx_symbol,
	input wire logic i_line_rx_valid,
	input wire logic i_line_rx_invalid,
	input wire logic i_line_rx_active,
	input wire logic i_line_collision,
	output logic [4:0] o_line_tx_symbol,
	output logic o_line_tx_enable,
	output logic o_line_tx_halt
);

	// ==========================================================
	// Pin synchronisers
	localparam int SYNC_W = 11;

	logic [SYNC_W-1:0] pin_async;
	logic [SYNC_W-1:0] pin_meta_reg;
	logic [SYNC_W-1:0] pin_sync_reg;
	mii_tx_t tx_pins;
	logic strap_sync;
	logic mgmt_clk_sync;
	logic mgmt_clk_prev_reg;
	cfg_t hw_cfg_sync;

	// Bit order low to high: tx nibble, enable, error, strap, mgmt clock, control pins
	assign pin_async = {i_hw_symbol_mode, i_hw_full_duplex, i_hw_speed100, i_mgmt_clock_p0,
		i_mgmt_disable_strap_p0, i_tx_error_p0, i_tx_enable_p0, i_tx_nibble_p0};

	always_ff @(posedge i_clk) begin
		pin_meta_reg <= pin_async;
		pin_sync_reg <= pin_meta_reg;
	end

	assign tx_pins = mii_tx_t'(pin_sync_reg[5:0]);
	assign strap_sync = pin_sync_reg[6];
	assign mgmt_clk_sync = pin_sync_reg[7];
	assign hw_cfg_sync = cfg_t'(pin_sync_reg[10:8]);

	// ==========================================================
	// Control bits and strap handling
	cfg_t cfg_reg;
	logic strap_reg;
	logic hw_loaded_reg;
	logic [1:0] settle_reg;
	logic mgmt_clk_seen_reg;
	logic bus_write_now;
	logic ctrl_hit;

	function automatic logic addr_is(input logic [2:0] addr, input logic [2:0] offset);
		return addr == offset;
	endfunction

	assign ctrl_hit = addr_is(i_address, `REG_CTRL_OFFSET);
	assign bus_write_now = i_write && !o_waitrequest;

	// Pins are captured after reset release, once the synchronisers hold real values
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			settle_reg <= 2'h0;
			hw_loaded_reg <= 1'b0;
		end else if (!hw_loaded_reg) begin
			if (settle_reg == 2'(`STRAP_SETTLE_CYCLES - 1)) begin
				hw_loaded_reg <= 1'b1;
			end else begin
				settle_reg <= settle_reg + 2'h1;
			end
		end
	end

	// Strap is frozen once the pins are loaded; only a reset samples it again
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			strap_reg <= 1'b0;
		end else if (!hw_loaded_reg) begin
			strap_reg <= strap_sync;
		end
	end

	// Strap high keeps the pins in charge; strap low hands the bits to the bus
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			cfg_reg <= cfg_t'(`CTRL_RESET_VALUE);
		end else if (!hw_loaded_reg) begin
			cfg_reg <= hw_cfg_sync;
		end else if (bus_write_now && ctrl_hit && i_byteenable[0] && !strap_reg) begin
			cfg_reg.speed100 <= i_writedata[`CTRL_SPEED100_BIT];
			cfg_reg.full_duplex <= i_writedata[`CTRL_FULL_DUPLEX_BIT];
			cfg_reg.symbol_mode <= i_writedata[`CTRL_SYMBOL_MODE_BIT];
		end
	end

	// Management port: disabled by the strap; no frame engine, so the line is never driven
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_mgmt_data_p0 <= 1'b0;
			o_mgmt_data_oe_p0 <= 1'b0;
		end else begin
			o_mgmt_data_p0 <= 1'b0;
			o_mgmt_data_oe_p0 <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			mgmt_clk_prev_reg <= 1'b0;
			mgmt_clk_seen_reg <= 1'b0;
		end else begin
			mgmt_clk_prev_reg <= mgmt_clk_sync;
			if (!strap_reg && hw_loaded_reg && mgmt_clk_sync && !mgmt_clk_prev_reg) begin
				mgmt_clk_seen_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// MII clock generation
	logic tx_fall;
	logic rx_fall;

	mii_clk_div u_tx_clk_div (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_speed100(cfg_reg.speed100),
		.o_mii_clk(o_tx_clock_p0),
		.o_rise(),
		.o_fall(tx_fall)
	);

	mii_clk_div u_rx_clk_div (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_speed100(cfg_reg.speed100),
		.o_mii_clk(o_rx_clock_p0),
		.o_rise(),
		.o_fall(rx_fall)
	);

	// ==========================================================
	// Transmit path: sample mid-period, away from the MAC's change after the rising edge
	line_tx_t line_tx_next;

	// Error becomes bit 4 in symbol mode, a halt request at 100 Mbps otherwise
	always_comb begin
		line_tx_next.en = tx_pins.en;
		line_tx_next.symbol = {1'b0, tx_pins.data};
		line_tx_next.halt = 1'b0;
		if (cfg_reg.symbol_mode) begin
			line_tx_next.symbol[4] = tx_pins.err;
		end else begin
			line_tx_next.halt = tx_pins.err && tx_pins.en && cfg_reg.speed100;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_line_tx_symbol <= 5'h00;
			o_line_tx_enable <= 1'b0;
			o_line_tx_halt <= 1'b0;
		end else if (tx_fall) begin
			o_line_tx_symbol <= line_tx_next.symbol;
			o_line_tx_enable <= line_tx_next.en;
			o_line_tx_halt <= line_tx_next.halt;
		end
	end

	// ==========================================================
	// Receive path: outputs change on the falling edge so the MAC samples on the rising edge
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_rx_nibble_p0 <= 4'h0;
			o_rx_valid_p0 <= 1'b0;
			o_rx_error_p0 <= 1'b0;
		end else if (rx_fall) begin
			o_rx_nibble_p0 <= i_line_rx_valid ? i_line_rx_symbol[3:0] : 4'h0;
			o_rx_valid_p0 <= i_line_rx_valid;
			if (cfg_reg.symbol_mode) begin
				o_rx_error_p0 <= i_line_rx_symbol[4];
			end else begin
				o_rx_error_p0 <= i_line_rx_invalid;
			end
		end
	end

	// ==========================================================
	// Collision and carrier sense: follow the line each system clock
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_collision_p0 <= 1'b0;
		end else begin
			o_collision_p0 <= i_line_collision && !cfg_reg.full_duplex;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_carrier_sense_p0 <= 1'b0;
		end else if (cfg_reg.full_duplex) begin
			o_carrier_sense_p0 <= i_line_rx_active;
		end else begin
			o_carrier_sense_p0 <= i_line_rx_active || o_line_tx_enable;
		end
	end

	// ==========================================================
	// Avalon-MM slave: one wait cycle, then the answer
	logic [31:0] read_word;

	always_comb begin
		read_word = 32'h0000_0000;
		if (ctrl_hit) begin
			read_word[`CTRL_SPEED100_BIT] = cfg_reg.speed100;
			read_word[`CTRL_FULL_DUPLEX_BIT] = cfg_reg.full_duplex;
			read_word[`CTRL_SYMBOL_MODE_BIT] = cfg_reg.symbol_mode;
		end else if (addr_is(i_address, `REG_STATUS_OFFSET)) begin
			read_word[`STAT_STRAP_BIT] = strap_reg;
			read_word[`STAT_COLLISION_BIT] = o_collision_p0;
			read_word[`STAT_CARRIER_BIT] = o_carrier_sense_p0;
			read_word[`STAT_MGMT_CLK_SEEN_BIT] = mgmt_clk_seen_reg;
			read_word[`STAT_RX_VALID_BIT] = o_rx_valid_p0;
			read_word[`STAT_HW_LOADED_BIT] = hw_loaded_reg;
		end
	end

	// Low for exactly one cycle, so a held request is answered every second cycle
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_waitrequest <= 1'b1;
		end else if ((i_read || i_write) && o_waitrequest) begin
			o_waitrequest <= 1'b0;
		end else begin
			o_waitrequest <= 1'b1;
		end
	end

	// Read data is taken on the request edge and holds until the next read
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_readdata <= 32'h0000_0000;
		end else if (i_read && o_waitrequest) begin
			o_readdata <= read_word;
		end
	end

endmodule

//--- mii_port_params.svh
`ifndef MII_PORT_PARAMS_SVH
`define MII_PORT_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define REG_CTRL_OFFSET 3'h0
`define REG_STATUS_OFFSET 3'h4

// ==========================================================
// Control field positions
`define CTRL_SPEED100_BIT 0
`define CTRL_FULL_DUPLEX_BIT 1
`define CTRL_SYMBOL_MODE_BIT 2

// ==========================================================
// Status field positions
`define STAT_STRAP_BIT 0
`define STAT_COLLISION_BIT 1
`define STAT_CARRIER_BIT 2
`define STAT_MGMT_CLK_SEEN_BIT 3
`define STAT_RX_VALID_BIT 4
`define STAT_HW_LOADED_BIT 5

// ==========================================================
// Reset values
`define CTRL_RESET_VALUE 3'h0

// ==========================================================
// Timing
`define SYS_CLK_PERIOD_PS 5000
`define MII_PERIOD_100_PS 40000
`define MII_PERIOD_10_PS 400000
`define MII_HALF_100_CYCLES (`MII_PERIOD_100_PS / (2 * `SYS_CLK_PERIOD_PS))
`define MII_HALF_10_CYCLES (`MII_PERIOD_10_PS / (2 * `SYS_CLK_PERIOD_PS))
`define STRAP_SETTLE_CYCLES 3

`endif

//--- mii_port_pkg.sv
package mii_port_pkg;

	typedef struct packed {
		logic symbol_mode;
		logic full_duplex;
		logic speed100;
	} cfg_t;

	typedef struct packed {
		logic err;
		logic en;
		logic [3:0] data;
	} mii_tx_t;

	typedef struct packed {
		logic halt;
		logic en;
		logic [4:0] symbol;
	} line_tx_t;

endpackage

//--- mii_port_props.sv
`timescale 1ns/1ps
module mii_port_props (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic o_waitrequest,
	input wire logic o_tx_clock_p0,
	input wire logic o_rx_clock_p0,
	input wire logic [3:0] o_rx_nibble_p0,
	input wire logic o_rx_valid_p0,
	input wire logic o_collision_p0,
	input wire logic i_line_collision,
	input wire logic [4:0] o_line_tx_symbol
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// ==========
	// Generated clock fell one cycle back
	sequence s_tx_fell;
		$past(o_tx_clock_p0, 2) && !$past(o_tx_clock_p0);
	endsequence
	sequence s_rx_fell;
		$past(o_rx_clock_p0, 2) && !$past(o_rx_clock_p0);
	endsequence
	property p_wait_low;
		(i_read || i_write) && o_waitrequest |=> !o_waitrequest;
	endproperty
	a_wait_low: assert property (p_wait_low) else $error("bus answer late");
	property p_tx_half;
		$changed(o_tx_clock_p0) |=> $stable(o_tx_clock_p0)[*3];
	endproperty
	a_tx_half: assert property (p_tx_half) else $error("tx clock too fast");
	property p_rx_half;
		$changed(o_rx_clock_p0) |=> $stable(o_rx_clock_p0)[*3];
	endproperty
	a_rx_half: assert property (p_rx_half) else $error("rx clock too fast");
	property p_rx_data;
		$changed(o_rx_nibble_p0) |-> s_rx_fell;
	endproperty
	a_rx_data: assert property (p_rx_data) else $error("rx nibble off clock");
	property p_rx_valid;
		$changed(o_rx_valid_p0) |-> s_rx_fell;
	endproperty
	a_rx_valid: assert property (p_rx_valid) else $error("rx valid off clock");
	property p_line_tx;
		$changed(o_line_tx_symbol) |-> s_tx_fell;
	endproperty
	a_line_tx: assert property (p_line_tx) else $error("tx sampled off clock");
	property p_col_on;
		o_collision_p0 |-> $past(i_line_collision);
	endproperty
	a_col_on: assert property (p_col_on) else $error("collision without cause");
	property p_col_off;
		!i_line_collision |=> !o_collision_p0;
	endproperty
	a_col_off: assert property (p_col_off) else $error("collision held too long");
endmodule
bind mii_port mii_port_props i_props (.i_clk, .i_resetn, .i_read, .i_write, .o_waitrequest, .o_tx_clock_p0,
	.o_rx_clock_p0, .o_rx_nibble_p0, .o_rx_valid_p0, .o_collision_p0, .i_line_collision, .o_line_tx_symbol);

//--- tb.sv
`timescale 1ns/1ps
`include "mii_port_params.svh"
module tb;
	import mii_port_pkg::*;
	logic i_clk = 1'b0, i_resetn = 1'b0, i_read = 1'b0, i_write = 1'b0, i_mgmt_disable_strap_p0 = 1'b0;
	logic i_hw_speed100 = 1'b1, i_hw_full_duplex = 1'b0, i_hw_symbol_mode = 1'b0, go = 1'b0, mdc, mdio;
	logic i_line_rx_valid = 1'b0, i_line_rx_invalid = 1'b0, i_line_rx_active = 1'b0, i_line_collision = 1'b0;
	logic o_waitrequest, o_tx_clock_p0, o_rx_clock_p0, o_rx_valid_p0, o_rx_error_p0, o_collision_p0;
	logic o_carrier_sense_p0, o_mgmt_data_p0, o_mgmt_data_oe_p0, o_line_tx_enable, o_line_tx_halt;
	logic [2:0] i_address = 3'h0;
	logic [3:0] be = 4'hf;
	logic [3:0] o_rx_nibble_p0;
	logic [4:0] i_line_rx_symbol = 5'h0, o_line_tx_symbol;
	logic [31:0] i_writedata = 32'h0, o_readdata, q;
	mii_tx_t word = '0, tx;
	int error_cnt = 0, tests_run = 0, n;
	always #2.5 i_clk = ~i_clk;
	mac_model i_mac (.i_clk, .i_tx_clock(o_tx_clock_p0), .i_word(word), .i_mgmt_go(go), .o_tx(tx), .o_mdc(mdc),
		.o_mdio(mdio));
	mii_port i_dut (.i_clk, .i_resetn, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable(be), .o_readdata,
		.o_waitrequest, .i_tx_nibble_p0(tx.data), .i_tx_enable_p0(tx.en), .i_tx_error_p0(tx.err), .o_tx_clock_p0,
		.o_rx_nibble_p0, .o_rx_valid_p0, .o_rx_error_p0, .o_rx_clock_p0, .o_collision_p0, .o_carrier_sense_p0,
		.i_mgmt_disable_strap_p0, .i_mgmt_clock_p0(mdc), .i_mgmt_data_p0(o_mgmt_data_oe_p0 ? o_mgmt_data_p0 : mdio),
		.o_mgmt_data_p0, .o_mgmt_data_oe_p0, .i_hw_speed100, .i_hw_full_duplex, .i_hw_symbol_mode, .i_line_rx_symbol,
		.i_line_rx_valid, .i_line_rx_invalid, .i_line_rx_active, .i_line_collision, .o_line_tx_symbol,
		.o_line_tx_enable, .o_line_tx_halt);
	// ==========
	// Tasks
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		int k;
		i_address <= a;
		i_writedata <= d;
		i_write <= w;
		i_read <= !w;
		for (k = 0; k < 50; k++) begin
			@(posedge i_clk);
			if (o_waitrequest === 1'b0) break;
		end
		if (k == 50) begin
			error_cnt++;
			print_verdict();
		end
		q = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic meas(input logic r);
		logic p, c;
		int k;
		n = 0;
		p = 1'b1;
		for (k = 0; k < 400; k++) begin
			@(posedge i_clk);
			c = r ? o_rx_clock_p0 : o_tx_clock_p0;
			if (c && !p && n > 0) break;
			if (c && !p) n = 1;
			else if (n > 0) n++;
			p = c;
		end
		if (k == 400) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	task automatic rst(input logic s);
		i_resetn <= 1'b0;
		i_mgmt_disable_strap_p0 <= s;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (6) @(posedge i_clk);
	endtask
	task automatic rxt(input logic [2:0] c, input logic [4:0] s, input logic v, input logic e, input logic [5:0] x);
		bus(1'b1, 3'h0, {29'h0, c});
		i_line_rx_symbol <= s;
		i_line_rx_valid <= v;
		i_line_rx_invalid <= e;
		repeat (40) @(posedge i_clk);
		chk("rx_out", {26'h0, x}, {26'h0, o_rx_error_p0, o_rx_valid_p0, o_rx_nibble_p0});
	endtask
	task automatic txt(input logic [2:0] c, input mii_tx_t w, input logic [6:0] x, input logic [6:0] m);
		bus(1'b1, 3'h0, {29'h0, c});
		word <= w;
		repeat (300) @(posedge i_clk);
		chk("line_tx", {25'h0, x}, {25'h0, {o_line_tx_halt, o_line_tx_enable, o_line_tx_symbol} & m});
	endtask
	// ==========
	// Tests
	initial begin
		rst(1'b0);
		bus(1'b0, 3'h0, 32'h0);
		chk("ctrl_pins", 32'h1, q);
		bus(1'b0, 3'h4, 32'h0);
		chk("status", 32'h20, q & 32'h21);
		bus(1'b0, 3'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		for (int s = 1; s >= 0; s--) begin
			bus(1'b1, 3'h0, s);
			bus(1'b0, 3'h0, 32'h0);
			chk("ctrl_wr", s, q);
			repeat (100) @(posedge i_clk);
			meas(1'b0);
			chk("tx_period", 2 * (s ? `MII_HALF_100_CYCLES : `MII_HALF_10_CYCLES), n);
			meas(1'b1);
			chk("rx_period", 2 * (s ? `MII_HALF_100_CYCLES : `MII_HALF_10_CYCLES), n);
		end
		be <= 4'he;
		bus(1'b1, 3'h0, 32'h1);
		be <= 4'hf;
		bus(1'b0, 3'h0, 32'h0);
		chk("ctrl_be", 32'h0, q);
		$display("test regs_clocks done");
		rxt(3'h1, 5'h0a, 1'b1, 1'b0, 6'h1a);
		rxt(3'h1, 5'h0a, 1'b0, 1'b1, 6'h20);
		rxt(3'h5, 5'h13, 1'b1, 1'b0, 6'h33);
		$display("test rx done");
		txt(3'h1, 6'h36, 7'h66, 7'h7f);
		txt(3'h1, 6'h26, 7'h00, 7'h60);
		txt(3'h0, 6'h36, 7'h26, 7'h7f);
		txt(3'h5, 6'h36, 7'h36, 7'h7f);
		$display("test tx done");
		word <= 6'h10;
		i_line_collision <= 1'b1;
		txt(3'h1, 6'h10, 7'h20, 7'h60);
		chk("half_col_crs", 32'h3, {30'h0, o_collision_p0, o_carrier_sense_p0});
		bus(1'b0, 3'h4, 32'h0);
		chk("status_col_crs", 32'h6, q & 32'h6);
		bus(1'b1, 3'h0, 32'h3);
		repeat (40) @(posedge i_clk);
		chk("full_col_crs", 32'h0, {30'h0, o_collision_p0, o_carrier_sense_p0});
		i_line_rx_active <= 1'b1;
		repeat (5) @(posedge i_clk);
		chk("full_crs_rx", 32'h1, {30'h0, o_collision_p0, o_carrier_sense_p0});
		i_line_collision <= 1'b0;
		$display("test col_crs done");
		go <= 1'b1;
		repeat (200) @(posedge i_clk);
		go <= 1'b0;
		bus(1'b0, 3'h4, 32'h0);
		chk("mgmt_seen", 32'h8, q & 32'h8);
		chk("mdio_oe", 32'h0, {30'h0, o_mgmt_data_oe_p0, o_mgmt_data_p0});
		$display("test mgmt done");
		i_hw_speed100 <= 1'b0;
		i_hw_full_duplex <= 1'b1;
		rst(1'b1);
		go <= 1'b1;
		repeat (200) @(posedge i_clk);
		go <= 1'b0;
		bus(1'b0, 3'h4, 32'h0);
		chk("strap", 32'h1, q & 32'h9);
		bus(1'b1, 3'h0, 32'h1);
		bus(1'b0, 3'h0, 32'h0);
		chk("ctrl_locked", 32'h2, q);
		$display("test strap done");
		print_verdict();
	end
endmodule
